// [rtl/dai_pkg.sv]
// Purpose: Constants for the digital audio input monitor.
// Assumes: 100 MHz pclk, APB register access.
// Notes:
package dai_pkg;
  localparam int CLK_HZ   = 100_000_000;
  localparam int RATE_48  = 48_000;
  localparam int RATE_44  = 44_100;
  localparam logic [15:0] PER_48 = 16'(CLK_HZ / RATE_48);
  localparam logic [15:0] PER_44 = 16'(CLK_HZ / RATE_44);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_RATE  = 8'h08;
  localparam logic [7:0] OFS_IRQS  = 8'h0C;
  localparam logic [7:0] OFS_IRQM  = 8'h10;
  localparam logic [7:0] OFS_NOM   = 8'h14;
  localparam logic [7:0] OFS_CNT0  = 8'h18;
  localparam logic [7:0] OFS_CNTN  = 8'h2C;

  // CTRL fields
  localparam int CTRL_SRC_LSB  = 0;
  localparam int CTRL_COPY_LSB = 2;
  localparam int CTRL_EMPH_LSB = 4;
  localparam int CTRL_RESEL    = 6;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] NOM_RST  = PER_48;

  // Source select codes
  localparam logic [1:0] SRC_EXT_BAL  = 2'h0;
  localparam logic [1:0] SRC_EXT_COAX = 2'h1;
  localparam logic [1:0] SRC_INT_48   = 2'h2;
  localparam logic [1:0] SRC_INT_44   = 2'h3;

  // Copy levels and emphasis modes
  localparam logic [1:0] COPY_NONE  = 2'h0;
  localparam logic [1:0] COPY_ONE   = 2'h1;
  localparam logic [1:0] COPY_MULTI = 2'h2;
  localparam logic [1:0] EMPH_NO    = 2'h0;
  localparam logic [1:0] EMPH_YES   = 2'h1;
  localparam logic [1:0] EMPH_PASS  = 2'h2;

  // Pro channel-status emphasis codes
  localparam logic [2:0] PEMPH_5015  = 3'h6;
  localparam logic [2:0] PEMPH_CCITT = 3'h7;

  // Error types, also counter index and irq bit
  localparam int NERR    = 6;
  localparam int E_VALID = 0;
  localparam int E_CONF  = 1;
  localparam int E_SLIP  = 2;
  localparam int E_CRC   = 3;
  localparam int E_PAR   = 4;
  localparam int E_BIP   = 5;
  localparam int IRQ_FB  = 6;
  localparam int NIRQ    = 7;

  localparam logic [13:0] CNT_LIMIT  = 14'd10000;
  localparam logic [13:0] CNT_SHOWN  = 14'd9999;
  localparam logic [2:0]  LOCK_GOOD  = 3'h4;
  localparam logic [15:0] SLIP_TOL   = 16'h0001;
  localparam int          TOL_NUM    = 25;

  typedef enum logic [3:0] {
    ST_INT = 4'b0001,
    ST_ACQ = 4'b0010,
    ST_EXT = 4'b0100,
    ST_FB  = 4'b1000
  } dai_state_t;
endpackage

// [rtl/dai_err_cnt.sv]
// Purpose: Saturating per-type error counter.
// Assumes: clr and inc come from pclk logic.
// Notes: Holds at the limit until cleared.
`timescale 1ns/1ps
module dai_err_cnt (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control
  input  wire logic        clr,
  input  wire logic        inc,
  // Result
  output logic [13:0] count,
  output logic        over
);
  logic [13:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 14'h0000;
    end else if (clr) begin
      cnt_r <= 14'h0000;
    end else if (inc && cnt_r != dai_pkg::CNT_LIMIT) begin
      cnt_r <= cnt_r + 14'h0001;
    end
  end

  assign count = cnt_r;
  assign over  = cnt_r > dai_pkg::CNT_SHOWN;
endmodule

// [rtl/dai_monitor.sv]
// Purpose: Digital audio input supervisor with APB registers.
// Assumes: Receiver front end gives per-frame flags, framed by link_clk.
// Notes: All link pins are asynchronous and pass two flip-flops.
`timescale 1ns/1ps
module dai_monitor (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic        pready,
  output logic [31:0] prdata,
  output logic        pslverr,
  output logic        irq,
  // Receiver front end
  input  wire logic        link_clk,
  input  wire logic        rx_lock,
  input  wire logic        rx_validity,
  input  wire logic        rx_parity_err,
  input  wire logic        rx_biphase_err,
  input  wire logic        rx_crc_err,
  input  wire logic        rx_jitter,
  input  wire logic        rx_nonaudio,
  input  wire logic        rx_pro,
  input  wire logic [2:0]  rx_emph_code,
  // Audio core side
  output logic        sample_tick,
  output logic        ext_clock_active,
  output logic        digin_mute,
  output logic        out_copy_bit,
  output logic        out_gen_bit,
  output logic        out_emph_flag
);
  localparam int SW = 12;

  // Synchroniser and link edge
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  logic          lclk_d_r;
  logic          edge_w;
  logic          l_lock;
  logic          l_valid;
  logic          l_par;
  logic          l_bip;
  logic          l_crc;
  logic          l_jit;
  logic          l_nona;
  logic          l_pro;
  logic [2:0]    l_emph;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r     <= '0;
      s2_r     <= '0;
      lclk_d_r <= 1'b0;
    end else begin
      s1_r     <= {link_clk, rx_lock, rx_validity, rx_parity_err, rx_biphase_err,
                   rx_crc_err, rx_jitter, rx_nonaudio, rx_pro, rx_emph_code};
      s2_r     <= s1_r;
      lclk_d_r <= s2_r[11];
    end
  end

  assign edge_w  = s2_r[11] & ~lclk_d_r;
  assign l_lock  = s2_r[10];
  assign l_valid = s2_r[9];
  assign l_par   = s2_r[8];
  assign l_bip   = s2_r[7];
  assign l_crc   = s2_r[6];
  assign l_jit   = s2_r[5];
  assign l_nona  = s2_r[4];
  assign l_pro   = s2_r[3];
  assign l_emph  = s2_r[2:0];

  function automatic logic in_range(input logic [15:0] m, input logic [15:0] n);
    logic [21:0] mm;
    logic [21:0] lo;
    logic [21:0] hi;
    mm = 22'(m) * 22'(dai_pkg::TOL_NUM);
    lo = 22'(n) * 22'(dai_pkg::TOL_NUM - 1);
    hi = 22'(n) * 22'(dai_pkg::TOL_NUM + 1);
    return (mm >= lo) && (mm <= hi);
  endfunction

  // Registers
  logic [31:0] ctrl_r;
  logic [15:0] nom_r;
  logic [dai_pkg::NIRQ-1:0] irqs_r;
  logic [dai_pkg::NIRQ-1:0] irqs_nxt;
  logic [dai_pkg::NIRQ-1:0] irqm_r;
  logic [31:0] prdata_r;

  logic        wr_w;
  logic        setup_w;
  logic        wr_ctrl;
  logic        wr_irqs;
  logic        wr_irqm;
  logic        wr_nom;
  logic        cnt_sel;
  logic [2:0]  cnt_idx;
  logic        mapped_w;
  logic [1:0]  src_w;
  logic [1:0]  new_src;
  logic        src_int;
  logic        new_ext;
  logic        resel_w;

  assign wr_w     = psel & penable & pwrite;
  assign setup_w  = psel & ~penable;
  assign wr_ctrl  = wr_w & (paddr == dai_pkg::OFS_CTRL);
  assign wr_irqs  = wr_w & (paddr == dai_pkg::OFS_IRQS);
  assign wr_irqm  = wr_w & (paddr == dai_pkg::OFS_IRQM);
  assign wr_nom   = wr_w & (paddr == dai_pkg::OFS_NOM);
  assign cnt_sel  = paddr >= dai_pkg::OFS_CNT0 && paddr <= dai_pkg::OFS_CNTN
                    && paddr[1:0] == 2'h0;
  assign cnt_idx  = 3'((paddr - dai_pkg::OFS_CNT0) >> 2);
  assign mapped_w = paddr == dai_pkg::OFS_CTRL || paddr == dai_pkg::OFS_STAT
                    || paddr == dai_pkg::OFS_RATE || paddr == dai_pkg::OFS_IRQS
                    || paddr == dai_pkg::OFS_IRQM || paddr == dai_pkg::OFS_NOM
                    || cnt_sel;
  assign src_w    = ctrl_r[dai_pkg::CTRL_SRC_LSB +: 2];
  assign new_src  = pwdata[dai_pkg::CTRL_SRC_LSB +: 2];
  assign src_int  = src_w[1];
  assign new_ext  = ~new_src[1];
  // Reselecting an external source restarts acquisition
  assign resel_w  = wr_ctrl & new_ext & (pwdata[dai_pkg::CTRL_RESEL] | src_int);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= dai_pkg::CTRL_RST;
      nom_r  <= dai_pkg::NOM_RST;
      irqm_r <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= {26'h0, pwdata[5:0]};
      end
      if (wr_nom) begin
        nom_r <= pwdata[15:0];
      end
      if (wr_irqm) begin
        irqm_r <= pwdata[dai_pkg::NIRQ-1:0];
      end
    end
  end

  // Rate measurement
  logic [15:0] per_cnt_r;
  logic [15:0] meas_r;
  logic [15:0] valid_per_r;
  logic        have_meas_r;
  logic [15:0] meas_now;
  logic        rate_ok;
  logic [15:0] dev_w;

  assign meas_now = per_cnt_r + 16'h0001;
  assign rate_ok  = in_range(meas_now, nom_r);
  assign dev_w    = meas_now > nom_r ? meas_now - nom_r : nom_r - meas_now;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_r   <= 16'h0000;
      meas_r      <= 16'h0000;
      have_meas_r <= 1'b0;
    end else if (edge_w) begin
      per_cnt_r   <= 16'h0000;
      meas_r      <= meas_now;
      have_meas_r <= 1'b1;
    end else if (per_cnt_r != 16'hFFFF) begin
      per_cnt_r <= per_cnt_r + 16'h0001;
    end
  end

  // Lock supervision
  dai_pkg::dai_state_t st_r;
  dai_pkg::dai_state_t st_nxt;
  logic [2:0]  good_r;
  logic        good_edge;
  logic        oor_r;
  logic        lost_w;
  logic        relock_w;
  logic        clr_cnt;

  assign good_edge = edge_w & l_lock & ~l_nona & rate_ok;
  assign lost_w    = ~l_lock | l_nona | (edge_w & ~rate_ok);
  assign relock_w  = (st_r == dai_pkg::ST_FB) && (st_nxt == dai_pkg::ST_EXT);
  assign clr_cnt   = resel_w | relock_w;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      dai_pkg::ST_INT: begin
        if (!src_int) begin
          st_nxt = dai_pkg::ST_ACQ;
        end
      end
      dai_pkg::ST_ACQ, dai_pkg::ST_FB: begin
        if (good_edge && good_r == dai_pkg::LOCK_GOOD - 3'h1) begin
          st_nxt = dai_pkg::ST_EXT;
        end
      end
      dai_pkg::ST_EXT: begin
        if (lost_w) begin
          st_nxt = dai_pkg::ST_FB;
        end
      end
    endcase
    if (src_int) begin
      st_nxt = dai_pkg::ST_INT;
    end else if (resel_w) begin
      st_nxt = dai_pkg::ST_ACQ;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r        <= dai_pkg::ST_INT;
      good_r      <= 3'h0;
      valid_per_r <= dai_pkg::PER_48;
      oor_r       <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r || (edge_w && !good_edge)) begin
        good_r <= 3'h0;
      end else if (good_edge && good_r != dai_pkg::LOCK_GOOD) begin
        good_r <= good_r + 3'h1;
      end
      if (st_r == dai_pkg::ST_EXT && good_edge) begin
        valid_per_r <= meas_now;
      end
      if (edge_w) begin
        oor_r <= ~rate_ok & ~src_int;
      end
    end
  end

  // Sample clock: link edges when locked, else internal divider
  logic [15:0] int_per;
  logic [15:0] int_cnt_r;
  logic        tick_r;
  logic        int_wrap;
  logic        ext_run;

  assign ext_run  = st_r == dai_pkg::ST_EXT;
  assign int_per  = src_w == dai_pkg::SRC_INT_44 ? dai_pkg::PER_44 :
                    src_w == dai_pkg::SRC_INT_48 ? dai_pkg::PER_48 : valid_per_r;
  assign int_wrap = int_cnt_r >= int_per - 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_cnt_r <= 16'h0000;
      tick_r    <= 1'b0;
    end else begin
      int_cnt_r <= int_wrap ? 16'h0000 : int_cnt_r + 16'h0001;
      // Mask a back-to-back pulse when the source swaps on a tick
      tick_r    <= (ext_run ? edge_w : int_wrap) & ~tick_r;
    end
  end

  // Live input status, kept on internal clock too
  logic pro_r;
  logic emph_in_r;
  logic emph_now;

  assign emph_now = l_pro ? (l_emph == dai_pkg::PEMPH_CCITT ||
                             l_emph == dai_pkg::PEMPH_5015) : l_emph[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pro_r     <= 1'b0;
      emph_in_r <= 1'b0;
    end else if (edge_w) begin
      pro_r     <= l_pro;
      emph_in_r <= emph_now;
    end
  end

  // Error events; the input is ignored when an internal rate is selected
  logic [dai_pkg::NERR-1:0] ev_w;
  logic                     ev_en;
  logic [2:0]               last_err_r;
  logic                     any_err_r;
  logic [2:0]               ev_idx;

  assign ev_en = edge_w & ~src_int & l_lock;
  assign ev_w[dai_pkg::E_VALID] = ev_en & l_valid;
  assign ev_w[dai_pkg::E_CONF]  = ev_en & l_jit;
  // Informational only: a slip never mutes
  assign ev_w[dai_pkg::E_SLIP]  = ev_en & have_meas_r & rate_ok
                                  & (dev_w > dai_pkg::SLIP_TOL);
  assign ev_w[dai_pkg::E_CRC]   = ev_en & l_crc;
  assign ev_w[dai_pkg::E_PAR]   = ev_en & l_par;
  assign ev_w[dai_pkg::E_BIP]   = ev_en & l_bip;

  always_comb begin
    ev_idx = 3'h0;
    for (int i = 0; i < dai_pkg::NERR; i++) begin
      if (ev_w[i]) begin
        ev_idx = 3'(i);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_err_r <= 3'h0;
      any_err_r  <= 1'b0;
    end else if (clr_cnt) begin
      any_err_r <= 1'b0;
    end else if (|ev_w) begin
      last_err_r <= ev_idx;
      any_err_r  <= 1'b1;
    end
  end

  logic [13:0] cnt_w [dai_pkg::NERR];
  logic [dai_pkg::NERR-1:0] over_w;

  for (genvar g = 0; g < dai_pkg::NERR; g++) begin : g_cnt
    dai_err_cnt u_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (clr_cnt),
      .inc     (ev_w[g]),
      .count   (cnt_w[g]),
      .over    (over_w[g])
    );
  end

  // Interrupts: set wins over write-one-to-clear
  logic fb_ev;
  assign fb_ev    = (st_r == dai_pkg::ST_EXT) && (st_nxt == dai_pkg::ST_FB);
  assign irqs_nxt = (irqs_r & ~(wr_irqs ? pwdata[dai_pkg::NIRQ-1:0] : '0))
                    | {fb_ev, ev_w};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqs_r <= '0;
    end else begin
      irqs_r <= irqs_nxt;
    end
  end

  assign irq = |(irqs_r & irqm_r);

  // Read mux
  logic [31:0] rd_w;
  logic [31:0] stat_w;
  logic [15:0] rate_w;

  assign stat_w = {20'h0, any_err_r, last_err_r, 2'h0, l_nona, oor_r,
                   digin_mute, emph_in_r, pro_r, ext_run};
  assign rate_w = ext_run ? meas_r : int_per;

  always_comb begin
    rd_w = 32'h0000_0000;
    if (paddr == dai_pkg::OFS_CTRL) begin
      rd_w = ctrl_r;
    end else if (paddr == dai_pkg::OFS_STAT) begin
      rd_w = stat_w;
    end else if (paddr == dai_pkg::OFS_RATE) begin
      rd_w = {16'h0, rate_w};
    end else if (paddr == dai_pkg::OFS_IRQS) begin
      rd_w = {25'h0, irqs_r};
    end else if (paddr == dai_pkg::OFS_IRQM) begin
      rd_w = {25'h0, irqm_r};
    end else if (paddr == dai_pkg::OFS_NOM) begin
      rd_w = {16'h0, nom_r};
    end else if (cnt_sel) begin
      rd_w = {17'h0, over_w[cnt_idx], cnt_w[cnt_idx]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_w) begin
      prdata_r <= rd_w;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = psel & penable & ~mapped_w;

  // Core side outputs
  logic [1:0] copy_w;
  logic [1:0] emod_w;
  logic       mute_r;
  logic       copy_r;
  logic       gen_r;
  logic       emph_o_r;

  assign copy_w = ctrl_r[dai_pkg::CTRL_COPY_LSB +: 2];
  assign emod_w = ctrl_r[dai_pkg::CTRL_EMPH_LSB +: 2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_r   <= 1'b1;
      copy_r   <= 1'b0;
      gen_r    <= 1'b0;
      emph_o_r <= 1'b0;
    end else begin
      // CRC errors deliberately absent from the mute term
      mute_r   <= ~ext_run | lost_w | oor_r;
      copy_r   <= copy_w == dai_pkg::COPY_MULTI;
      gen_r    <= copy_w == dai_pkg::COPY_ONE;
      emph_o_r <= emod_w == dai_pkg::EMPH_YES ? 1'b1 :
                  emod_w == dai_pkg::EMPH_PASS ? emph_in_r : 1'b0;
    end
  end

  assign sample_tick      = tick_r;
  assign ext_clock_active = ext_run;
  assign digin_mute       = mute_r;
  assign out_copy_bit     = copy_r;
  assign out_gen_bit      = gen_r;
  assign out_emph_flag    = emph_o_r;
endmodule

// [verification/dai_monitor_assertions.sv]
// Purpose: Port-level checks for the audio input monitor.
// Assumes: One pclk domain, presetn async active low.
// Notes: Link pins pass two flops, so reactions get a few cycles of slack.
`timescale 1ns/1ps
module dai_monitor_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Observed pins
  input wire logic pslverr,
  input wire logic rx_lock,
  input wire logic rx_nonaudio,
  input wire logic sample_tick,
  input wire logic ext_clock_active,
  input wire logic digin_mute,
  input wire logic out_copy_bit,
  input wire logic out_gen_bit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_lock_loss;
    ext_clock_active && !rx_lock |-> ##[1:6] !ext_clock_active;
  endproperty
  a_lock_loss: assert property (p_lock_loss) else $error("lock loss kept external");

  // Flag pin may lead the sampling link edge by half a frame
  property p_nonaudio;
    ext_clock_active && rx_nonaudio |-> ##[1:12] !ext_clock_active;
  endproperty
  a_nonaudio: assert property (p_nonaudio) else $error("non-audio kept external");

  property p_unlock_mute;
    !rx_lock [*6] |-> digin_mute;
  endproperty
  a_unlock_mute: assert property (p_unlock_mute) else $error("unlocked but unmuted");

  property p_fall_mute;
    $fell(ext_clock_active) |-> ##[0:1] digin_mute;
  endproperty
  a_fall_mute: assert property (p_fall_mute) else $error("fallback without mute");

  property p_relock_unmute;
    $rose(ext_clock_active) |-> ##[0:2] !digin_mute;
  endproperty
  a_relock_unmute: assert property (p_relock_unmute) else $error("relock stayed muted");

  property p_ext_no_mute;
    ext_clock_active [*3] |-> !digin_mute;
  endproperty
  a_ext_no_mute: assert property (p_ext_no_mute) else $error("muted while locked");

  property p_tick;
    sample_tick |=> !sample_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("sample tick too long");

  property p_copy;
    !(out_copy_bit && out_gen_bit);
  endproperty
  a_copy: assert property (p_copy) else $error("illegal copy code");

  c_lock: cover property ($rose(ext_clock_active));
  c_fall: cover property ($fell(ext_clock_active));
  c_err: cover property (pslverr);
endmodule

bind dai_monitor dai_monitor_assertions i_chk (.pclk(pclk), .presetn(presetn),
  .pslverr(pslverr), .rx_lock(rx_lock), .rx_nonaudio(rx_nonaudio),
  .sample_tick(sample_tick), .ext_clock_active(ext_clock_active),
  .digin_mute(digin_mute), .out_copy_bit(out_copy_bit), .out_gen_bit(out_gen_bit));

// [verification/dai_tx_model.sv]
// Purpose: Far-end transmitter and receiver front end for the bench.
// Assumes: Flags change on the falling link edge, held a whole frame.
// Notes: Idle link holds the clock low and lets the data lines wander.
`timescale 1ns/1ps
module dai_tx_model (
  // Bench control
  input  wire logic        run,
  input  wire logic [15:0] per_ns,
  input  wire logic [9:0]  req,
  input  wire logic        lock_req,
  // Receiver pins
  output logic        link_clk,
  output logic        rx_lock,
  output logic [9:0]  flags
);
  assign rx_lock = lock_req;
  initial begin
    link_clk = 1'b0;
    flags = 10'h000;
    #3;
    forever begin
      if (run) begin
        #(per_ns / 2.0) link_clk = 1'b1;
        #(per_ns / 2.0) link_clk = 1'b0;
        flags = req;
      end else begin
        // Stale data must not look valid between frames
        #(per_ns / 2.0) flags = ~flags;
      end
    end
  end
endmodule

// [verification/tb_digital_audio_input_monitor.sv]
// Purpose: Self-checking bench for the audio input monitor.
// Assumes: 100 MHz pclk; link at 80 ns nominal, 125 ns as the off-rate case.
// Notes: Nominal period of 8 cycles keeps counter saturation inside the run.
`timescale 1ns/1ps
module tb_digital_audio_input_monitor;
  logic        pclk, pready, pslverr, irq, err, link_clk, rx_lock, sample_tick;
  logic        ext_clock_active, digin_mute, out_copy_bit, out_gen_bit, out_emph_flag;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        run = 1'b0, lock_req = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [9:0]  req = 10'h000, base = 10'h000, flags;
  logic [15:0] per_ns = 16'd80;
  int          failures = 0, compares = 0, n;
  int          ety[5] = '{0, 1, 3, 4, 5};
  logic [4:0]  emt[5] = '{5'h1F, 5'h1E, 5'h08, 5'h11, 5'h00};

  dai_tx_model i_tx (.run(run), .per_ns(per_ns), .req(req), .lock_req(lock_req),
    .link_clk(link_clk), .rx_lock(rx_lock), .flags(flags));
  dai_monitor i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq(irq), .link_clk(link_clk), .rx_lock(rx_lock),
    .rx_validity(flags[0]), .rx_jitter(flags[1]), .rx_nonaudio(flags[2]),
    .rx_crc_err(flags[3]), .rx_parity_err(flags[4]), .rx_biphase_err(flags[5]),
    .rx_pro(flags[6]), .rx_emph_code(flags[9:7]), .sample_tick(sample_tick),
    .ext_clock_active(ext_clock_active), .digin_mute(digin_mute),
    .out_copy_bit(out_copy_bit), .out_gen_bit(out_gen_bit), .out_emph_flag(out_emph_flag));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) failures++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic wait_ext(input logic v);
    int k;
    k = 0;
    while (ext_clock_active !== v && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    if (k == 2000) failures++;
    settle();
  endtask

  // Exactly cnt frames carry f; the rest carry only the background bits
  task automatic frames(input logic [9:0] f, input int cnt);
    @(posedge link_clk);
    @(posedge pclk);
    req <= base | f;
    repeat (cnt) @(posedge link_clk);
    @(posedge pclk);
    req <= base;
    repeat (3) @(posedge link_clk);
    settle();
  endtask

  function automatic logic [31:0] exp_cnt(input int c);
    return (c > 9999) ? {17'h0, 1'b1, dai_pkg::CNT_LIMIT} : 32'(c);
  endfunction

  function automatic logic [2:0] exp_out(input int cp, input int em, input logic inc);
    return {(em == 2) ? inc : (em == 1), cp == 1, cp == 2};
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    failures++;
    print_verdict();
  end

  initial begin
    void'($urandom(76));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wr(dai_pkg::OFS_CTRL, 32'h0000_0002);
    rd(dai_pkg::OFS_RATE);
    chk(q, 32'(dai_pkg::PER_48));
    run <= 1'b1;
    lock_req <= 1'b1;
    frames(10'h001, 5);
    rd(dai_pkg::OFS_CNT0);
    chk(q, 32'h0);
    chk(ext_clock_active, 1'b0);
    for (int cp = 0; cp < 3; cp++) begin
      for (int em = 0; em < 2; em++) begin
        wr(dai_pkg::OFS_CTRL, 32'(3 + 4 * cp + 16 * em));
        settle();
        chk({out_emph_flag, out_gen_bit, out_copy_bit}, exp_out(cp, em, 1'b0));
      end
    end
    rd(dai_pkg::OFS_RATE);
    chk(q, 32'(dai_pkg::PER_44));
    rd(8'h30);
    chk({31'h0, err}, 32'h1);
    chk(q, 32'h0);
    $display("test internal done");
    wr(dai_pkg::OFS_NOM, 32'd8);
    wr(dai_pkg::OFS_IRQM, 32'h0000_007F);
    wr(dai_pkg::OFS_CTRL, 32'h0000_0028);
    wait_ext(1'b1);
    chk({ext_clock_active, digin_mute}, 2'b10);
    rd(dai_pkg::OFS_RATE);
    chk(q, 32'd8);
    // One tick per link frame while locked: 80 cycles hold 10 frames
    n = 0;
    repeat (80) begin
      @(posedge pclk);
      #1;
      n += int'(sample_tick);
    end
    chk(32'(n), 32'd10);
    foreach (emt[i]) begin
      base <= {emt[i][2:0], emt[i][3], 6'h00};
      frames(10'h000, 4);
      rd(dai_pkg::OFS_STAT);
      chk(q[2:1], emt[i][4:3]);
      chk(out_emph_flag, emt[i][4]);
    end
    $display("test lock done");
    foreach (ety[i]) begin
      n = $urandom_range(20, 1);
      frames(10'(1 << ety[i]), n);
      rd(dai_pkg::OFS_CNT0 + 8'(4 * ety[i]));
      chk(q, exp_cnt(n));
      rd(dai_pkg::OFS_STAT);
      chk({q[10:8], digin_mute, irq}, {3'(ety[i]), 2'b01});
    end
    wr(dai_pkg::OFS_IRQM, 32'h0);
    settle();
    chk(irq, 1'b0);
    wr(dai_pkg::OFS_IRQM, 32'h0000_007F);
    wr(dai_pkg::OFS_IRQS, 32'h0000_007F);
    settle();
    chk(irq, 1'b0);
    wr(dai_pkg::OFS_CTRL, 32'h0000_0068);
    rd(dai_pkg::OFS_CNT0 + 8'h14);
    chk(q, 32'h0);
    wait_ext(1'b1);
    frames(10'h001, 10001);
    rd(dai_pkg::OFS_CNT0);
    chk(q, exp_cnt(10001));
    $display("test errors done");
    per_ns <= 16'd125;
    wait_ext(1'b0);
    chk(digin_mute, 1'b1);
    rd(dai_pkg::OFS_STAT);
    chk(q[4], 1'b1);
    rd(dai_pkg::OFS_RATE);
    chk(q, 32'd8);
    per_ns <= 16'd80;
    wait_ext(1'b1);
    chk(ext_clock_active, 1'b1);
    rd(dai_pkg::OFS_CNT0);
    chk(q, 32'h0);
    @(posedge pclk);
    lock_req <= 1'b0;
    wait_ext(1'b0);
    chk(digin_mute, 1'b1);
    @(posedge pclk);
    lock_req <= 1'b1;
    wait_ext(1'b1);
    wr(dai_pkg::OFS_IRQS, 32'h0000_007F);
    frames(10'h004, 3);
    rd(dai_pkg::OFS_IRQS);
    chk(q[6], 1'b1);
    wait_ext(1'b1);
    chk(ext_clock_active, 1'b1);
    $display("test fallback done");
    wr(dai_pkg::OFS_NOM, 32'd60);
    per_ns <= 16'd620;
    wait_ext(1'b0);
    wait_ext(1'b1);
    frames(10'h000, 4);
    rd(dai_pkg::OFS_CNT0 + 8'h08);
    chk(32'(q[13:0] != 14'h0), 32'h1);
    $display("test slip done");
    print_verdict();
  end
endmodule
